// *** core/sadc_top.sv ***
/*
 converter control sequencer for a 10-bit successive approximation
 converter: registers, clock divider, acquisition and conversion sequencing.
 assumes a classic wishbone master, a front end whose comparator decision
 follows dac_code within one clock, and asynchronous pin levels.
*/
// Local design decision: the Wishbone slave port.
// Functional notes
// - four-bit channel code picks inputs 0-12, core supply or band gap
// - negative reference is external pin when select is one, else ground
// - positive reference is external pin when select is one, else supply
// - busy bit reads one during a conversion and zero when idle
// - enable bit turns the converter on and off
// - format bit one gives right justified result, zero left
// - calibration request makes next conversion a calibration
// - acquisition code gives 0,2,4,6,8,12,16,20 conversion periods
// - clock select picks oscillator divisors or the internal rc clock
// - rc clock starts one instruction cycle after the start
// - pin config one makes pin digital, zero analog with input zero
// - all pin config bits reset to zero, analog mode
// - band gap powered while its enable bit or another module asks
// - reserved bit kept zero by software, unimplemented bit reads zero
// - at conversion end result stored, busy cleared, done flag set
// - reset restores registers, turns converter off, aborts conversion
// - result registers untouched by reset
// - conversion continues in sleep only on the rc clock
// - result built by successive approximation on held sample
// - unimplemented channel returns arbitrary value without error
// - result is an unsigned ten-bit value
// - one conversion takes eleven conversion clock periods
// - nonzero acquisition code samples first, zero converts at once
// - after a conversion sampling of the selected channel resumes
`timescale 1ns/1ps
`default_nettype none
module sadc_top
	import sadc_pkg::*;
#(
	parameter int RC_DIV = RC_HALF
) (
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [13:0]          wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic [3:0]           wb_sel_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 comparator_in,
	input  wire logic [12:0]          pin_level_in,
	input  wire logic                 bandgap_request_in,
	input  wire logic                 sleep_in,
	output sadc_pkg::sadc_analog_t    analog_out,
	output logic                      bandgap_power,
	output logic [12:0]               pin_digital_select,
	output logic [12:0]               pin_digital_in,
	output logic                      conversion_done_flag
);
	import sadc_pkg::*;

	if (RC_DIV < 1 || RC_DIV > 127) begin : g_rc_div_check
		$error("RC_DIV out of range");
	end

	function automatic logic [4:0] acq_periods(input logic [2:0] code);
		case (code)
			3'h0: acq_periods = 5'd0;
			3'h1: acq_periods = 5'd2;
			3'h2: acq_periods = 5'd4;
			3'h3: acq_periods = 5'd6;
			3'h4: acq_periods = 5'd8;
			3'h5: acq_periods = 5'd12;
			3'h6: acq_periods = 5'd16;
			default: acq_periods = 5'd20;
		endcase
	endfunction

	function automatic logic [6:0] half_div(input logic [2:0] code);
		case (code)
			3'h0: half_div = 7'd1;
			3'h1: half_div = 7'd4;
			3'h2: half_div = 7'd16;
			3'h4: half_div = 7'd2;
			3'h5: half_div = 7'd8;
			3'h6: half_div = 7'd32;
			default: half_div = 7'(RC_DIV);
		endcase
	endfunction

	logic [7:0]  control;
	logic [7:0]  config_reg;
	logic [7:0]  pin_low;
	logic [7:0]  pin_high;
	logic [15:0] result;
	sadc_state_t state;
	logic [6:0]  div_cnt;
	logic [4:0]  per_cnt;
	logic [3:0]  bit_idx;
	logic [9:0]  sar;
	logic [7:0]  tcy_cnt;
	logic        cal_active;
	logic        half_ph;
	logic [12:0] pin_s1, pin_s2;
	logic        bg_s1, bg_s2;
	logic        slp_s1, slp_s2;

	// bus decode
	wire         bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [11:0]  bus_idx   = wb_adr_i[13:2];
	wire         wr_lane   = bus_req && wb_we_i && wb_sel_i[0];
	wire         wr_ctl    = wr_lane && bus_idx == IDX_CONTROL;
	wire         wr_cfg    = wr_lane && bus_idx == IDX_CONFIG;
	wire         wr_plo    = wr_lane && bus_idx == IDX_PIN_LOW;
	wire         wr_phi    = wr_lane && bus_idx == IDX_PIN_HIGH;
	wire         enabled   = control[CTL_ENABLE];
	wire [2:0]   clk_sel   = config_reg[CFG_CLK_HI:CFG_CLK_LO];
	wire [2:0]   acq_code  = config_reg[CFG_ACQ_HI:CFG_ACQ_LO];
	wire         start_req = wr_ctl && wb_dat_i[CTL_BUSY] && wb_dat_i[CTL_ENABLE];
	wire         en_next   = wr_ctl ? wb_dat_i[CTL_ENABLE] : enabled;
	// two half periods of the divider make one conversion clock period
	wire         half_end  = div_cnt == 7'd0;
	wire         tick      = half_end && half_ph;
	// sleep halts the oscillator clocks, the rc clock keeps running
	wire         run_ok    = !slp_s2 || clk_sel == CLK_RC;
	wire         busy      = state != SADC_IDLE;
	// divider held while idle and through the rc start delay
	wire         clk_hold  = !busy || state == SADC_WAIT;
	wire         conv_end  = state == SADC_CONV && tick && run_ok
	                         && per_cnt == 5'(CONV_PERIODS - 1);
	// trial bit for the current approximation step
	wire [9:0]   trial     = sar | (10'h200 >> bit_idx);
	// comparator decision is latched on this clock, no synchroniser
	wire [9:0]   final_val = (bit_idx < 4'(RES_BITS) && comparator_in)
	                         ? trial : sar;
	wire [15:0]  packed_res = config_reg[CFG_FORMAT]
	                         ? {PAD_ZERO, final_val}
	                         : {final_val, PAD_ZERO};
	wire [7:0]   ctl_view  = {control[7:2], busy && enabled, control[0]};
	wire [7:0]   phi_view  = pin_high & PH_WRITE_MASK;

	logic [7:0] rd_byte;
	always_comb begin
		case (bus_idx)
			IDX_CONTROL:   rd_byte = ctl_view;
			IDX_CONFIG:    rd_byte = config_reg;
			IDX_PIN_LOW:   rd_byte = pin_low;
			IDX_PIN_HIGH:  rd_byte = phi_view;
			IDX_RESULT_HI: rd_byte = result[15:8];
			IDX_RESULT_LO: rd_byte = result[7:0];
			IDX_STATUS:    rd_byte = {7'h00, conversion_done_flag};
			default:       rd_byte = 8'h00;
		endcase
	end

	// synchronisers
	always_ff @(posedge mclk) begin
		pin_s1 <= pin_level_in;
		pin_s2 <= pin_s1;
		bg_s1  <= bandgap_request_in;
		bg_s2  <= bg_s1;
		slp_s1 <= sleep_in;
		slp_s2 <= slp_s1;
	end

	// bus answer
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= {24'h000000, rd_byte};
		end
	end

	// registers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			control    <= RST_REG;
			config_reg <= RST_REG;
			pin_low    <= RST_REG;
			pin_high   <= RST_REG;
		end else begin
			if (wr_ctl)
				control <= {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
			if (wr_cfg)
				config_reg <= wb_dat_i[7:0];
			else if (conv_end && cal_active)
				config_reg[CFG_CAL] <= 1'b0;
			if (wr_plo)
				pin_low <= wb_dat_i[7:0];
			if (wr_phi)
				pin_high <= wb_dat_i[7:0] & PH_WRITE_MASK;
		end
	end

	// result pair keeps its value across reset
	always_ff @(posedge mclk) begin
		if (resetn && conv_end)
			result <= packed_res;
	end

	// done flag, set wins over clear
	always_ff @(posedge mclk) begin
		if (!resetn)
			conversion_done_flag <= 1'b0;
		else if (conv_end)
			conversion_done_flag <= 1'b1;
		else if (wr_lane && bus_idx == IDX_STATUS && !wb_dat_i[0])
			conversion_done_flag <= 1'b0;
	end

	// sequencer
	always_ff @(posedge mclk) begin
		if (!resetn || !en_next) begin
			state      <= SADC_IDLE;
			div_cnt    <= 7'd0;
			half_ph    <= 1'b0;
			per_cnt    <= 5'd0;
			bit_idx    <= 4'd0;
			sar        <= 10'h000;
			tcy_cnt    <= 8'd0;
			cal_active <= 1'b0;
		end else begin
			div_cnt <= (half_end || clk_hold)
			           ? half_div(clk_sel) - 7'd1 : div_cnt - 7'd1;
			half_ph <= clk_hold ? 1'b0 : half_ph ^ half_end;
			case (state)
				SADC_IDLE: begin
					if (start_req) begin
						cal_active <= config_reg[CFG_CAL];
						per_cnt    <= 5'd0;
						sar        <= 10'h000;
						bit_idx    <= 4'd0;
						tcy_cnt    <= 8'(TCY_CYCLES);
						if (clk_sel == CLK_RC)
							state <= SADC_WAIT;
						else if (acq_periods(acq_code) != 5'd0)
							state <= SADC_ACQ;
						else
							state <= SADC_CONV;
					end
				end
				SADC_WAIT: begin
					tcy_cnt <= tcy_cnt - 8'd1;
					if (tcy_cnt == 8'd1)
						state <= (acq_periods(acq_code) != 5'd0)
						         ? SADC_ACQ : SADC_CONV;
				end
				SADC_ACQ: begin
					if (tick && run_ok) begin
						if (per_cnt == acq_periods(acq_code) - 5'd1) begin
							per_cnt <= 5'd0;
							state   <= SADC_CONV;
						end else
							per_cnt <= per_cnt + 5'd1;
					end
				end
				SADC_CONV: begin
					if (tick && run_ok) begin
						// first period holds, ten periods decide a bit each
						if (per_cnt != 5'd0 && bit_idx < 4'(RES_BITS)) begin
							sar     <= comparator_in ? trial : sar;
							bit_idx <= bit_idx + 4'd1;
						end
						if (conv_end)
							state <= SADC_IDLE;
						else
							per_cnt <= per_cnt + 5'd1;
					end
				end
				default: state <= SADC_IDLE;
			endcase
		end
	end

	// outputs to the analog front end, all registered
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			analog_out         <= '0;
			bandgap_power      <= 1'b0;
			pin_digital_select <= 13'h0000;
			pin_digital_in     <= 13'h0000;
		end else begin
			// reserved and unimplemented codes pass through, value arbitrary
			analog_out.channel_select   <= control[CTL_CH_HI:CTL_CH_LO];
			analog_out.neg_ref_select   <= control[CTL_NEG_REF];
			analog_out.pos_ref_select   <= control[CTL_POS_REF];
			analog_out.sample_hold      <= state == SADC_CONV;
			analog_out.calibrate        <= cal_active && busy;
			analog_out.bandgap_enable   <= pin_high[PH_BANDGAP];
			analog_out.converter_enable <= enabled;
			analog_out.dac_code         <= trial;
			bandgap_power      <= pin_high[PH_BANDGAP] || bg_s2;
			pin_digital_select <= {pin_high[4:0], pin_low};
			pin_digital_in     <= {pin_high[4:0], pin_low} & pin_s2;
		end
	end

	// assertions
	busy_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end |=> !busy && conversion_done_flag)
		else $error("busy not cleared at conversion end");
	conv_length_a: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end |-> per_cnt == 5'(CONV_PERIODS - 1))
		else $error("conversion length wrong");
	zero_acq_a: assert property (@(posedge mclk) disable iff (!resetn)
		state == SADC_IDLE && start_req && clk_sel != CLK_RC
		&& acq_code == 3'h0 |=> state == SADC_CONV)
		else $error("zero acquisition did not convert at once");
	rc_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
		state == SADC_IDLE && start_req && clk_sel == CLK_RC
		|=> state == SADC_WAIT)
		else $error("rc clock started without wait");
	disable_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
		!enabled |-> state == SADC_IDLE)
		else $error("disabled converter not idle");
	right_just_a: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end && config_reg[CFG_FORMAT] |=> result[15:10] == PAD_ZERO)
		else $error("right justified upper bits not zero");
	left_just_a: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end && !config_reg[CFG_FORMAT] |=> result[5:0] == PAD_ZERO)
		else $error("left justified lower bits not zero");
	digital_in_a: assert property (@(posedge mclk) disable iff (!resetn)
		##1 (pin_digital_in & ~pin_digital_select) == 13'h0000)
		else $error("analog pin reads nonzero");
	bandgap_on_a: assert property (@(posedge mclk) disable iff (!resetn)
		pin_high[PH_BANDGAP] |=> bandgap_power)
		else $error("band gap not powered");
	reserved_rd_a: assert property (@(posedge mclk) disable iff (!resetn)
		phi_view[6:5] == 2'b00)
		else $error("reserved bits read nonzero");
	status_view_a: assert property (@(posedge mclk) disable iff (!resetn)
		ctl_view[CTL_BUSY] == (busy && enabled))
		else $error("status bit mismatch");
	channel_out_a: assert property (@(posedge mclk) disable iff (!resetn)
		##1 analog_out.channel_select == $past(control[5:2]))
		else $error("channel not routed");
	rc_wait_len_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(state == SADC_WAIT) |-> (state == SADC_WAIT || !enabled) [*4])
		else $error("rc start delay wrong");
	result_load_a: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end |=> result == $past(packed_res))
		else $error("result not stored at conversion end");
	bandgap_off_a: assert property (@(posedge mclk) disable iff (!resetn)
		!pin_high[PH_BANDGAP] && !bg_s2 |=> !bandgap_power)
		else $error("band gap powered without request");
	pin_reset_a: assert property (@(posedge mclk)
		!resetn |=> pin_low == RST_REG && pin_high == RST_REG)
		else $error("pin config not analog after reset");
	abort_reset_a: assert property (@(posedge mclk)
		!resetn |=> state == SADC_IDLE && !wb_ack_o && !conversion_done_flag)
		else $error("reset did not abort");
	sleep_halt_a: assert property (@(posedge mclk) disable iff (!resetn)
		state == SADC_CONV && !run_ok && en_next
		|=> $stable(per_cnt) && $stable(sar))
		else $error("conversion ran in sleep");
	calib_out_a: assert property (@(posedge mclk) disable iff (!resetn)
		cal_active && busy |=> analog_out.calibrate)
		else $error("calibration not signalled");
	hold_out_a: assert property (@(posedge mclk) disable iff (!resetn)
		##1 analog_out.sample_hold == $past(state == SADC_CONV))
		else $error("sample hold wrong");
	refs_out_a: assert property (@(posedge mclk) disable iff (!resetn)
		##1 {analog_out.neg_ref_select, analog_out.pos_ref_select}
		== $past(control[CTL_NEG_REF:CTL_POS_REF]))
		else $error("reference select not routed");
	acq_start_a: assert property (@(posedge mclk) disable iff (!resetn)
		state == SADC_IDLE && start_req && clk_sel != CLK_RC
		&& acq_code != 3'h0 |=> state == SADC_ACQ)
		else $error("acquisition not started");
	bit_count_a: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end |-> bit_idx == 4'(RES_BITS - 1))
		else $error("wrong number of bit decisions");
	sar_step_a: assert property (@(posedge mclk) disable iff (!resetn)
		state == SADC_CONV && tick && run_ok && per_cnt != 5'd0 && en_next
		|=> bit_idx == $past(bit_idx) + 4'd1)
		else $error("approximation step skipped");
endmodule
`default_nettype wire

// *** include/sadc_pkg.sv ***
/*
 package for the converter control sequencer: register offsets, fields,
 reset values, timing constants and carrier structs.
 assumes a classic wishbone slave with 32-bit data, one register a word.
*/
package sadc_pkg;
	// register indices (printed offsets), byte address is four times these
	localparam logic [11:0] IDX_PIN_LOW   = 12'hF48;
	localparam logic [11:0] IDX_PIN_HIGH  = 12'hF49;
	localparam logic [11:0] IDX_CONFIG    = 12'hFC1;
	localparam logic [11:0] IDX_CONTROL   = 12'hFC2;
	localparam logic [11:0] IDX_RESULT_HI = 12'hFC4;
	localparam logic [11:0] IDX_RESULT_LO = 12'hFC3;
	localparam logic [11:0] IDX_STATUS    = 12'hFC5;

	localparam logic [7:0] RST_REG = 8'h00;

	// control fields
	localparam int CTL_NEG_REF = 7;
	localparam int CTL_POS_REF = 6;
	localparam int CTL_CH_HI   = 5;
	localparam int CTL_CH_LO   = 2;
	localparam int CTL_BUSY    = 1;
	localparam int CTL_ENABLE  = 0;
	// config fields
	localparam int CFG_FORMAT  = 7;
	localparam int CFG_CAL     = 6;
	localparam int CFG_ACQ_HI  = 5;
	localparam int CFG_ACQ_LO  = 3;
	localparam int CFG_CLK_HI  = 2;
	localparam int CFG_CLK_LO  = 0;
	// high pin config fields
	localparam int PH_BANDGAP  = 7;
	localparam logic [7:0] PH_WRITE_MASK = 8'h9F;

	localparam logic [3:0] CH_RESERVED = 4'hD;
	localparam logic [3:0] CH_CORE     = 4'hE;
	localparam logic [3:0] CH_BANDGAP  = 4'hF;
	localparam logic [2:0] CLK_RC      = 3'h3;

	localparam int RES_BITS    = 10;
	localparam int CONV_PERIODS = 11;
	localparam logic [5:0] PAD_ZERO = 6'h00;

	// instruction cycle delay before the rc clock starts
	localparam int TCY_NS      = 20;
	localparam int CLK_NS      = 5;
	localparam int TCY_CYCLES  = (TCY_NS + CLK_NS - 1) / CLK_NS;
	localparam int RC_HALF     = 8;

	typedef enum logic [3:0] {
		SADC_IDLE = 4'b0001,
		SADC_WAIT = 4'b0010,
		SADC_ACQ  = 4'b0100,
		SADC_CONV = 4'b1000
	} sadc_state_t;

	typedef struct packed {
		logic [3:0] channel_select;
		logic       neg_ref_select;
		logic       pos_ref_select;
		logic       sample_hold;
		logic       calibrate;
		logic       bandgap_enable;
		logic       converter_enable;
		logic [9:0] dac_code;
	} sadc_analog_t;
endpackage

// *** dv/sadc_front_model.sv ***
/*
 front end model: a held analog sample and an ideal comparator.
 assumes dac_code settles before the sequencer samples comparator_in.
*/
`timescale 1ns/1ps
`default_nettype none
module sadc_front_model
	import sadc_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic [9:0]             level,
	input  wire sadc_pkg::sadc_analog_t analog_out,
	output logic                        comparator_in
);
	logic [9:0] held;
	// track while sampling, freeze while holding
	always_ff @(posedge mclk) begin
		if (!analog_out.sample_hold)
			held <= level;
	end
	// input sits half a step above held, so no ties
	assign comparator_in = (analog_out.dac_code <= held);
endmodule
`default_nettype wire

// *** dv/tb_sar_adc_control_sequencer.sv ***
/*
 self-checking bench: register traffic and random conversions.
 assumes a one-cycle wishbone answer and the front end model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_control_sequencer;
	import sadc_pkg::*;
	localparam int RCD = 3;
	localparam int HV[8] = '{1, 4, 16, RCD, 2, 8, 32, 1};
	localparam int AQ[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	localparam logic [11:0] ridx[5] = '{IDX_PIN_LOW, IDX_PIN_HIGH,
		IDX_CONFIG, IDX_CONTROL, 12'h123};
	logic         mclk, resetn, cyc, stb, we, cmp, slp, bgr, ack, bgp, done;
	logic         seen;
	logic [13:0]  adr;
	logic [31:0]  dati, dato;
	logic [12:0]  lvl, dsel, din;
	logic [9:0]   level;
	logic [7:0]   q, q2, ctl, cfg;
	logic [15:0]  res;
	sadc_analog_t ana;
	int           error_cnt, num_checks, seed, n, cyc_n, t0, h, base;

	sadc_top #(.RC_DIV(RCD)) dut (.mclk(mclk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dati), .wb_sel_i(4'hF), .wb_dat_o(dato), .wb_ack_o(ack),
		.comparator_in(cmp), .pin_level_in(lvl), .bandgap_request_in(bgr),
		.sleep_in(slp), .analog_out(ana), .bandgap_power(bgp),
		.pin_digital_select(dsel), .pin_digital_in(din),
		.conversion_done_flag(done));
	sadc_front_model fe (.mclk(mclk), .level(level), .analog_out(ana),
		.comparator_in(cmp));

	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc_n <= cyc_n + 1;

	function automatic logic [15:0] exp_res(input logic [9:0] v,
		input logic f);
		return f ? {PAD_ZERO, v} : {v, PAD_ZERO};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [11:0] idx,
		input logic [7:0] d, output logic [7:0] r);
		int k;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {idx, 2'h0};
		dati <= {24'h0, d};
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'h1 && k < 20);
		if (ack !== 1'h1) begin
			chk(32'h0, 32'h1);
			summarize();
		end
		r = dato[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge mclk);
	endtask

	task automatic conv(input logic [2:0] cs, input logic [2:0] aq,
		input logic fm, input logic cl, input logic [3:0] ch);
		int k;
		level <= 10'($random(seed));
		slp <= (cs == CLK_RC);
		wb(1'h1, IDX_STATUS, 8'h00, q);
		wb(1'h1, IDX_CONFIG, {fm, cl, aq, cs}, q);
		ctl = {2'($random(seed)), ch, 2'h3};
		wb(1'h1, IDX_CONTROL, ctl, q);
		t0 = cyc_n;
		chk(ana.channel_select, ch);
		chk(ana.neg_ref_select, ctl[7]);
		chk(ana.pos_ref_select, ctl[6]);
		chk(ana.converter_enable, 1'h1);
		wb(1'h0, IDX_CONTROL, 8'h00, q);
		chk(q, ctl);
		seen = 1'h0;
		for (k = 0; k < 5000 && done !== 1'h1; k++) begin
			@(posedge mclk);
			seen = seen | ana.calibrate;
		end
		h = HV[cs];
		base = (AQ[aq] + CONV_PERIODS) * 2 * h;
		k = cyc_n - t0;
		chk(k >= base - 2 * h + 1 && k <= base + 12, 1'h1);
		chk(seen, cl);
		wb(1'h0, IDX_CONTROL, 8'h00, q);
		chk(q, {ctl[7:2], 2'h1});
		chk(ana.sample_hold, 1'h0);
		wb(1'h0, IDX_RESULT_HI, 8'h00, q);
		wb(1'h0, IDX_RESULT_LO, 8'h00, q2);
		res = {q, q2};
		chk(res, exp_res(level, fm));
		wb(1'h0, IDX_STATUS, 8'h00, q);
		chk(q, 8'h01);
		wb(1'h0, IDX_CONFIG, 8'h00, q);
		chk(q, {fm, 1'h0, aq, cs});
		repeat (4 * h) @(posedge mclk);
	endtask

	initial begin
		seed = 10184;
		error_cnt = 0;
		num_checks = 0;
		cyc_n = 0;
		{cyc, stb, we, slp, bgr, resetn} = 6'h0;
		{adr, dati, lvl, level} = '0;
		repeat (5) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
		foreach (ridx[i]) begin
			wb(1'h0, ridx[i], 8'h00, q);
			chk(q, RST_REG);
		end
		for (n = 0; n < 4; n++) begin
			ctl = 8'($random(seed));
			cfg = 8'($random(seed)) & 8'hBF;
			lvl <= 13'($random(seed));
			bgr <= 1'($random(seed));
			wb(1'h1, IDX_PIN_LOW, ctl, q);
			wb(1'h1, IDX_PIN_HIGH, cfg, q);
			wb(1'h1, 12'h123, 8'hFF, q);
			wb(1'h0, 12'h123, 8'h00, q);
			chk(q, 8'h00);
			wb(1'h0, IDX_PIN_HIGH, 8'h00, q);
			chk(q, cfg & PH_WRITE_MASK);
			chk(dsel, {cfg[4:0], ctl});
			chk(din, lvl & {cfg[4:0], ctl});
			chk(bgp, cfg[7] | bgr);
			chk(ana.bandgap_enable, cfg[7]);
		end
		conv(3'h0, 3'h0, 1'h1, 1'h0, CH_BANDGAP);
		conv(3'h6, 3'h7, 1'h0, 1'h1, CH_CORE);
		conv(CLK_RC, 3'h1, 1'h0, 1'h0, CH_RESERVED);
		for (n = 0; n < 12; n++)
			conv(3'($unsigned($random(seed)) % 7), 3'($random(seed)),
				1'($random(seed)), 1'($random(seed)), 4'($random(seed)));
		// sleep on a divided clock halts, then disable aborts
		slp <= 1'h1;
		wb(1'h1, IDX_STATUS, 8'h00, q);
		wb(1'h1, IDX_CONFIG, 8'h00, q);
		wb(1'h1, IDX_CONTROL, 8'h03, q);
		repeat (100) @(posedge mclk);
		chk(done, 1'h0);
		wb(1'h0, IDX_CONTROL, 8'h00, q);
		chk(q, 8'h03);
		wb(1'h1, IDX_CONTROL, 8'h00, q);
		slp <= 1'h0;
		repeat (100) @(posedge mclk);
		chk({done, ana.converter_enable}, 2'h0);
		// reset in mid acquisition, before the conversion periods start
		level <= ~level;
		wb(1'h1, IDX_CONFIG, 8'h3E, q);
		wb(1'h1, IDX_CONTROL, 8'h03, q);
		repeat (50) @(posedge mclk);
		resetn <= 1'h0;
		repeat (5) @(posedge mclk);
		resetn <= 1'h1;
		@(posedge mclk);
		wb(1'h0, IDX_CONTROL, 8'h00, q);
		chk(q, RST_REG);
		wb(1'h0, IDX_RESULT_HI, 8'h00, q);
		wb(1'h0, IDX_RESULT_LO, 8'h00, q2);
		chk({q, q2}, res);
		repeat (2100) @(posedge mclk);
		chk({done, ana.sample_hold, ana.converter_enable}, 3'h0);
		summarize();
	end
endmodule
`default_nettype wire
